// file: dv/dss_master.sv
/*
 * host model: two-wire bus master and chip-select driver.
 * assumes sda is the resolved open-drain wire with a pull-up and that
 * the caller runs one task at a time.
 */
`default_nettype none

module dss_master (
   input  wire logic clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sdaPull,
   output logic      chipSelN
);
   timeunit 1ns;
   timeprecision 1ns;

   // ----------------------------------------
   // idle levels
   // ----------------------------------------
   initial begin
      scl      = 1'b1; // bus clock stands still between frames
      sdaPull  = 1'b0;
      chipSelN = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   // ----------------------------------------
   // bus primitives
   // ----------------------------------------
   task automatic startCond();
      @(posedge clk) sdaPull <= 1'b1;
      tick(4);
   endtask : startCond

   // called just after an edge: 4 clk low, 4 clk high, a 400 ns bit
   task automatic bitXfer(input logic b, output logic r);
      scl <= 1'b0;
      @(posedge clk) sdaPull <= ~b;
      tick(3);
      scl <= 1'b1;
      tick(2);
      r = sda;
      tick(2);
   endtask : bitXfer

   // a read byte passes b = ff and releases; ack 1 is a not-acknowledge
   task automatic byteXfer(input logic [7:0] b, input logic ack,
                           output logic [7:0] r, output logic ackSeen);
      for (int i = 7; i >= 0; i--) bitXfer(b[i], r[i]);
      bitXfer(ack, ackSeen);
   endtask : byteXfer

   task automatic stopCond();
      @(posedge clk) scl <= 1'b0;
      @(posedge clk) sdaPull <= 1'b1;
      tick(3);
      scl <= 1'b1;
      tick(4);
      sdaPull <= 1'b0;
      tick(4);
   endtask : stopCond

   task automatic holdLow(input int n);
      @(posedge clk) scl <= 1'b0;
      tick(n);
   endtask : holdLow

   task automatic csPulses(input int n);
      repeat (n) begin
         @(posedge clk) chipSelN <= 1'b0;
         tick(4);
         chipSelN <= 1'b1;
         tick(4);
      end
   endtask : csPulses

endmodule : dss_master

`default_nettype wire

// file: dv/dss_slave_tb.sv
/*
 * self-checking bench of the dual serial slave front end.
 * assumes dss_defs.svh on the include path and dss_master as the host.
 */
`default_nettype none
`include "dss_defs.svh"

`define DSS_CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
   $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module dss_slave_tb
   import dss_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ----------------------------------------
   // setup
   // ----------------------------------------
   localparam int         TO_CYC = 200; // short timeout keeps the run brief
   localparam logic [7:0] DEV_ID = 8'h6e; // arbitrary value
   localparam logic [7:0] MK_ID  = 8'h2d; // arbitrary value
   localparam logic [3:0] VER    = 4'h2; // arbitrary value
   localparam logic [3:0] STEP   = 4'h5; // arbitrary value

   logic       clk, rst, swReset, sdaOut, sdaOe, fourWireLocked;
   logic       scl, sdaPull, chipSelN, sda;
   logic [1:0] addrPinLevel;
   logic [6:0] devAddr;
   int         failures = 0;
   int         n_checks = 0;
   logic [1:0] pins [3] = '{`DSS_PIN_LOW, `DSS_PIN_FLOAT, `DSS_PIN_HIGH};
   logic [2:0] lows [3] = '{`DSS_ADDR_LOW_GND, `DSS_ADDR_LOW_FLOAT, `DSS_ADDR_LOW_VCC};

   assign sda = (sdaOe ? sdaOut : 1'b1) & ~sdaPull; // pull-up wins when released

   dss_slave #(.DEVICE_IDENTIFIER(DEV_ID), .MAKER_ID(MK_ID), .VERSION(VER), .STEPPING(STEP),
      .TIMEOUT_CYCLES(TO_CYC)) dut_u (.clk(clk), .rst(rst), .sclIn(scl), .sdaIn(sda),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .chipSelN(chipSelN), .addrPinLevel(addrPinLevel),
      .swReset(swReset), .fourWireLocked(fourWireLocked));

   dss_master mst_u (.clk(clk), .sda(sda), .scl(scl), .sdaPull(sdaPull),
      .chipSelN(chipSelN));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] x;
      x = c ^ b;
      for (int i = 0; i < 8; i++) x = {x[6:0], 1'b0} ^ (x[7] ? `DSS_CRC_POLY : 8'h00);
      return x;
   endfunction : crc8

   task automatic conclude();
      if (failures == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude

   task automatic powerUp(input logic [1:0] pin);
      @(posedge clk) rst <= 1'b1;
      addrPinLevel <= pin;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : powerUp

   // n bytes: address, pointer, data, check byte (flipped by pecFlip)
   task automatic wrFrame(input logic [7:0] ptr, input logic [7:0] dat, input int n,
                          input logic [7:0] pecFlip);
      logic [7:0] b [4];
      logic [7:0] r;
      logic       a;
      b[0] = {devAddr, 1'b0};
      b[1] = ptr;
      b[2] = dat;
      b[3] = crc8(crc8(crc8(8'h00, b[0]), ptr), dat) ^ pecFlip;
      mst_u.startCond();
      for (int i = 0; i < n; i++) begin
         mst_u.byteXfer(b[i], 1'b1, r, a);
         `DSS_CHK("wrAck", 1'b0, a)
      end
      mst_u.stopCond();
      `DSS_CHK("idleOe", 1'b0, sdaOe)
      `DSS_CHK("sdaOut", 1'b0, sdaOut)
   endtask : wrFrame

   task automatic rdReg(input logic [7:0] ptr, input logic [7:0] exp, input logic pec,
                        input logic setPtr);
      logic [7:0] d;
      logic [7:0] c;
      logic       a;
      if (setPtr) wrFrame(ptr, 8'h00, 2, 8'h00);
      mst_u.startCond();
      mst_u.byteXfer({devAddr, 1'b1}, 1'b1, d, a);
      `DSS_CHK("rdAddrAck", 1'b0, a)
      mst_u.byteXfer(8'hff, ~pec, d, a);
      `DSS_CHK("rdData", exp, d)
      if (pec) begin
         mst_u.byteXfer(8'hff, 1'b1, c, a);
         `DSS_CHK("rdPec", crc8(crc8(8'h00, {devAddr, 1'b1}), exp), c)
      end
      mst_u.stopCond();
   endtask : rdReg

   task automatic probe(input logic [6:0] ad, input logic expAck);
      logic [7:0] r;
      logic       a;
      mst_u.startCond();
      mst_u.byteXfer({ad, 1'b0}, 1'b1, r, a);
      mst_u.stopCond();
      `DSS_CHK("probeAck", expAck, a)
   endtask : probe

   // address byte, then the bus clock stalls low inside the acknowledge
   task automatic stallAck(input logic expOe);
      logic [7:0] b;
      logic [7:0] r;
      logic       a;
      b = {devAddr, 1'b0};
      mst_u.startCond();
      for (int i = 7; i >= 0; i--) mst_u.bitXfer(b[i], r[i]);
      mst_u.holdLow(TO_CYC + 60);
      `DSS_CHK("stallOe", expOe, sdaOe)
      mst_u.bitXfer(1'b1, a);
      mst_u.stopCond();
   endtask : stallAck

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      conclude();
   end

   initial begin
      rst = 1'b1;
      swReset = 1'b0;
      addrPinLevel = `DSS_PIN_LOW;
      for (int p = 0; p < 3; p++) begin
         powerUp(pins[p]);
         `DSS_CHK("lockAtPowerUp", 1'b0, fourWireLocked)
         devAddr = {`DSS_ADDR_UPPER, lows[p]};
         probe(devAddr ^ 7'h01, 1'b1);
         probe(devAddr, 1'b0);
         probe(devAddr, 1'b0);
         @(posedge clk) addrPinLevel <= pins[(p + 1) % 3];
         probe({`DSS_ADDR_UPPER, lows[(p + 1) % 3]}, 1'b1);
         probe(devAddr, 1'b0);
      end
      rdReg(`DSS_OFS_DEVICE_IDENTIFIER, DEV_ID, 1'b1, 1'b1);
      rdReg(`DSS_OFS_MAKER_ID, MK_ID, 1'b0, 1'b1);
      rdReg(`DSS_OFS_MAKER_ID, MK_ID, 1'b1, 1'b0);
      rdReg(`DSS_OFS_SILICON_REV, {VER, STEP}, 1'b0, 1'b1);
      // lock status is only ever read: a host write there is forbidden
      rdReg(`DSS_OFS_LOCK_STATUS, 8'h00, 1'b0, 1'b1);
      rdReg(8'h30, `DSS_UNMAPPED_READ, 1'b0, 1'b1);
      rdReg(`DSS_OFS_CONTROL_TWO, `DSS_CTRL2_RESET, 1'b0, 1'b1);
      wrFrame(`DSS_OFS_DEVICE_IDENTIFIER, 8'h00, 3, 8'h00);
      rdReg(`DSS_OFS_DEVICE_IDENTIFIER, DEV_ID, 1'b0, 1'b1);
      stallAck(1'b1);
      wrFrame(`DSS_OFS_CONTROL_TWO, 8'h40, 4, 8'h01);
      rdReg(`DSS_OFS_CONTROL_TWO, 8'h00, 1'b0, 1'b1);
      wrFrame(`DSS_OFS_CONTROL_TWO, 8'h40, 4, 8'h00);
      rdReg(`DSS_OFS_CONTROL_TWO, 8'h40, 1'b1, 1'b1);
      stallAck(1'b0);
      probe(devAddr, 1'b0);
      mst_u.csPulses(2);
      mst_u.tick(8);
      `DSS_CHK("lockAfterTwo", 1'b0, fourWireLocked)
      mst_u.csPulses(1);
      mst_u.tick(8);
      `DSS_CHK("lockAfterThree", 1'b1, fourWireLocked)
      probe(devAddr, 1'b1);
      @(posedge clk) swReset <= 1'b1;
      @(posedge clk) swReset <= 1'b0;
      mst_u.tick(8);
      `DSS_CHK("lockAfterSwReset", 1'b1, fourWireLocked)
      conclude();
   end

endmodule : dss_slave_tb

`default_nettype wire

// file: hw/dss_slave.sv
/*
 * two-wire slave front end with chip-select driven four-wire lock,
 * late-latched pin address, optional bus timeout and crc-8 packet check.
 * assumes: sclIn, sdaIn, chipSelN and addrPinLevel are asynchronous pins;
 * sdaIn is the resolved open-drain wire; swReset is a clk-domain pulse.
 */
// Functional notes
// - port starts in two-wire mode; nothing can lock two-wire mode.
// - third chip-select rising edge selects and locks four-wire mode.
// - four-wire lock holds until power is removed.
// - software reset leaves interface selection and lock untouched.
// - lock status bit 0 reads 1 once locked, 0 in two-wire mode.
// - address is 1001 plus pin code: low 000, float 010, high 011.
// - pin address latched at eighth clock of second matching transfer.
// - control two bit 6 enables 25 ms inactivity timeout; default off.
// - packet check happens only if master clocks the extra byte.
// - packet check byte is crc-8, polynomial x^8+x^2+x+1.
// - after start, seven address bits msb first plus direction shift in.
// - matching address acknowledged by pulling data low for ninth clock.
// - direction 0 means master writes, 1 means master reads.
// - bytes take nine clocks; data moves only while clock is low.
// - direction fixed per transfer; no mixing read and write.
// - no register address auto-increment in two-wire mode.
// - read-only device and maker identifier registers at 4d and 4e.
// - revision register: stepping low nibble, version high nibble.
// - pointer set by the pointer byte of any write; software reset clears it.
`default_nettype none
`include "dss_defs.svh"

module dss_slave
   import dss_pkg::*;
#(
   parameter logic [7:0] DEVICE_IDENTIFIER      = 8'h5a, // arbitrary value
   parameter logic [7:0] MAKER_ID       = 8'hc3, // arbitrary value
   parameter logic [3:0] VERSION        = 4'h1,  // arbitrary value
   parameter logic [3:0] STEPPING       = 4'h0,  // arbitrary value
   parameter int         TIMEOUT_CYCLES = `DSS_TIMEOUT_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       sclIn,
   input  wire logic       sdaIn,
   output logic            sdaOut,
   output logic            sdaOe,
   input  wire logic       chipSelN,
   input  wire logic [1:0] addrPinLevel,
   input  wire logic       swReset,
   output logic            fourWireLocked
);

   if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= (1 << `DSS_CNT_W)) begin : g_badTimeout
      $error("TIMEOUT_CYCLES does not fit the timeout counter");
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] r;
      r = c ^ b;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ `DSS_CRC_POLY) : (r << 1);
      end
      return r;
   endfunction : crc8

   function automatic logic [7:0] regRead(input logic [7:0] p, input logic [7:0] c2,
                                          input logic lk);
      unique case (p)
         `DSS_OFS_DEVICE_IDENTIFIER:   regRead = DEVICE_IDENTIFIER;
         `DSS_OFS_MAKER_ID:    regRead = MAKER_ID;
         `DSS_OFS_SILICON_REV: regRead = {VERSION, STEPPING};
         `DSS_OFS_LOCK_STATUS: regRead = {7'h00, lk};
         `DSS_OFS_CONTROL_TWO: regRead = c2;
         default:              regRead = `DSS_UNMAPPED_READ;
      endcase
   endfunction : regRead

   function automatic logic [2:0] pinCode(input logic [1:0] lv);
      unique case (lv)
         `DSS_PIN_LOW:   pinCode = `DSS_ADDR_LOW_GND;
         `DSS_PIN_FLOAT: pinCode = `DSS_ADDR_LOW_FLOAT;
         default:        pinCode = `DSS_ADDR_LOW_VCC;
      endcase
   endfunction : pinCode

   dssRegs_t q;
   dssRegs_t n;

   logic sclRise;
   logic sclFall;
   logic startCond;
   logic stopCond;
   logic activity;
   logic csRise;
   logic [6:0] ownAddr;

   assign sclRise   = q.sclS2 & ~q.sclD;
   assign sclFall   = ~q.sclS2 & q.sclD;
   assign startCond = q.sclS2 & q.sclD & q.sdaD & ~q.sdaS2;
   assign stopCond  = q.sclS2 & q.sclD & ~q.sdaD & q.sdaS2;
   assign activity  = (q.sclS2 ^ q.sclD) | (q.sdaS2 ^ q.sdaD);
   assign csRise    = q.csS2 & ~q.csD;
   // address follows the pin until the second matching transfer freezes it
   assign ownAddr   = {`DSS_ADDR_UPPER, q.addrLatched ? q.addrLow : pinCode(q.pinS2)};

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic [7:0] b;
      logic [7:0] rd;
      b  = {q.shift[6:0], q.sdaS2};
      rd = regRead(q.ptr, q.ctrlTwo, q.locked);
      n = q;
      n.sclS1 = sclIn;
      n.sclS2 = q.sclS1;
      n.sclD  = q.sclS2;
      n.sdaS1 = sdaIn;
      n.sdaS2 = q.sdaS1;
      n.sdaD  = q.sdaS2;
      n.csS1  = chipSelN;
      n.csS2  = q.csS1;
      n.csD   = q.csS2;
      n.pinS1 = addrPinLevel;
      n.pinS2 = q.pinS1;

      // only chip-select pulses can move the port out of two-wire mode
      if (!q.locked && csRise) begin
         n.csEdges = q.csEdges + 2'h1;
         if (q.csEdges == `DSS_CS_PULSES - 2'h1) begin
            n.locked = 1'b1;
         end
      end

      if (swReset) begin
         n.ctrlTwo = `DSS_CTRL2_RESET;
         n.ptr     = 8'h00;
      end

      if (q.st == DSS_IDLE || activity) begin
         n.toCnt = '0;
      end else begin
         n.toCnt = q.toCnt + dssCnt_t'(1);
      end

      if (q.locked) begin
         // four-wire framing lives elsewhere; two-wire engine stays parked
         n.st     = DSS_IDLE;
         n.sdaDrv = 1'b0;
      end else if (startCond) begin
         n.st      = DSS_ADDR;
         n.bitCnt  = 4'h0;
         n.crc     = 8'h00;
         n.byteCnt = 2'h0;
         n.pecOk   = 1'b0;
         n.sdaDrv  = 1'b0;
      end else if (stopCond) begin
         if (q.st != DSS_IDLE && !q.isRead && q.ptr == `DSS_OFS_CONTROL_TWO &&
             (q.byteCnt == 2'h2 || (q.byteCnt == 2'h3 && q.pecOk))) begin
            n.ctrlTwo = q.dataW;
         end
         n.st     = DSS_IDLE;
         n.sdaDrv = 1'b0;
      end else if (q.st != DSS_IDLE && q.ctrlTwo[`DSS_CTRL2_TIMEOUT_BIT] &&
                   q.toCnt == dssCnt_t'(TIMEOUT_CYCLES - 1)) begin
         n.st     = DSS_IDLE;
         n.sdaDrv = 1'b0;
      end else if (sclRise) begin
         unique case (q.st)
            DSS_ADDR: begin
               n.shift  = b;
               n.bitCnt = q.bitCnt + 4'h1;
               if (q.bitCnt == 4'h7) begin
                  if (b[7:1] == ownAddr) begin
                     n.st     = DSS_ADDR_ACK;
                     n.isRead = b[0];
                     n.crc    = crc8(q.crc, b);
                     if (!q.addrLatched) begin
                        n.matchSeen = 1'b1;
                        if (q.matchSeen) begin
                           n.addrLatched = 1'b1;
                           n.addrLow     = pinCode(q.pinS2);
                        end
                     end
                  end else begin
                     n.st = DSS_IDLE;
                  end
               end
            end
            DSS_WR_BYTE: begin
               n.shift  = b;
               n.bitCnt = q.bitCnt + 4'h1;
               if (q.bitCnt == 4'h7) begin
                  n.st  = DSS_WR_ACK;
                  n.crc = crc8(q.crc, b);
                  if (q.byteCnt != 2'h3) begin
                     n.byteCnt = q.byteCnt + 2'h1;
                  end
                  unique case (q.byteCnt)
                     2'h0: n.ptr   = b;
                     2'h1: n.dataW = b;
                     2'h2: n.pecOk = (b == q.crc);
                     default: n.pecOk = 1'b0;
                  endcase
               end
            end
            DSS_RD_BYTE: begin
               n.bitCnt = q.bitCnt + 4'h1;
               if (q.bitCnt == 4'h7) begin
                  n.st = DSS_RD_ACK;
               end
            end
            DSS_RD_ACK: begin
               if (q.sdaS2) begin
                  n.st = DSS_IDLE;
               end else begin
                  // acknowledged data earns the crc byte: the optional check
                  n.txByte = q.crc;
                  n.crc    = crc8(q.crc, q.crc);
                  n.st     = DSS_RD_BYTE;
                  n.bitCnt = 4'h0;
               end
            end
            default: ;
         endcase
      end else if (sclFall) begin
         unique case (q.st)
            DSS_ADDR_ACK: begin
               if (!q.sdaDrv) begin
                  n.sdaDrv = 1'b1;
               end else if (q.isRead) begin
                  n.txByte = rd;
                  n.crc    = crc8(q.crc, rd);
                  n.st     = DSS_RD_BYTE;
                  n.bitCnt = 4'h0;
                  n.sdaDrv = ~rd[7];
               end else begin
                  n.st     = DSS_WR_BYTE;
                  n.bitCnt = 4'h0;
                  n.sdaDrv = 1'b0;
               end
            end
            DSS_WR_ACK: begin
               if (!q.sdaDrv) begin
                  n.sdaDrv = 1'b1;
               end else begin
                  n.st     = DSS_WR_BYTE;
                  n.bitCnt = 4'h0;
                  n.sdaDrv = 1'b0;
               end
            end
            DSS_RD_BYTE: begin
               if (q.bitCnt == 4'h0) begin
                  n.sdaDrv = ~q.txByte[7];
               end else begin
                  n.sdaDrv = ~q.txByte[3'h7 - q.bitCnt[2:0]];
               end
            end
            DSS_RD_ACK: n.sdaDrv = 1'b0;
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '{st: DSS_IDLE, ctrlTwo: `DSS_CTRL2_RESET, sclS1: 1'b1, sclS2: 1'b1,
                sclD: 1'b1, sdaS1: 1'b1, sdaS2: 1'b1, sdaD: 1'b1, csS1: 1'b1,
                csS2: 1'b1, csD: 1'b1, default: '0};
      end else begin
         q <= n;
      end
   end

   // open drain: only ever pull low
   assign sdaOut         = 1'b0;
   assign sdaOe          = q.sdaDrv;
   assign fourWireLocked = q.locked;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_thirdCsEdge;
      !q.locked && csRise && q.csEdges == 2'h2;
   endsequence

   sequence s_ackBegins;
      q.st == DSS_ADDR_ACK && sclFall && !q.sdaDrv;
   endsequence

   property p_lockOnThird;
      s_thirdCsEdge |=> q.locked && fourWireLocked;
   endproperty
   a_lockOnThird: assert property (p_lockOnThird) else $error("no lock on third edge");

   property p_lockSticky;
      q.locked |=> q.locked;
   endproperty
   a_lockSticky: assert property (p_lockSticky) else $error("four-wire lock was lost");

   property p_swResetKeepsLock;
      swReset |=> q.locked == $past(q.locked) && q.ctrlTwo == `DSS_CTRL2_RESET;
   endproperty
   a_swResetKeepsLock: assert property (p_swResetKeepsLock) else $error("sw reset hit lock");

   property p_lockedQuiet;
      q.locked |=> !sdaOe;
   endproperty
   a_lockedQuiet: assert property (p_lockedQuiet) else $error("data driven while locked");

   property p_ackDrive;
      s_ackBegins and !startCond and !stopCond |=> sdaOe;
   endproperty
   a_ackDrive: assert property (p_ackDrive) else $error("address not acknowledged");

   property p_idleReleased;
      q.st == DSS_IDLE |-> !sdaOe;
   endproperty
   a_idleReleased: assert property (p_idleReleased) else $error("data held in idle");

   property p_addrFrozen;
      q.addrLatched |=> q.addrLatched && $stable(q.addrLow);
   endproperty
   a_addrFrozen: assert property (p_addrFrozen) else $error("latched address moved");

   property p_timeout;
      !q.locked && !startCond && !stopCond && q.st != DSS_IDLE &&
      q.ctrlTwo[`DSS_CTRL2_TIMEOUT_BIT] && q.toCnt == dssCnt_t'(TIMEOUT_CYCLES - 1)
      |=> q.st == DSS_IDLE;
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout did not abandon");

   property p_startShifts;
      !q.locked && startCond |=> q.st == DSS_ADDR && q.bitCnt == 4'h0 && !sdaOe;
   endproperty
   a_startShifts: assert property (p_startShifts) else $error("start not taken");

endmodule : dss_slave

`default_nettype wire

// file: shared/dss_defs.svh
/*
 * constants of the dual serial slave front end: register offsets, field
 * positions, reset values, address pattern and timing counts.
 * assumes it is included by bare name from the package and the design.
 */
`ifndef DSS_DEFS_SVH
`define DSS_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define DSS_OFS_DEVICE_IDENTIFIER    8'h4d
`define DSS_OFS_MAKER_ID     8'h4e
`define DSS_OFS_SILICON_REV  8'h4f
`define DSS_OFS_LOCK_STATUS  8'h7f
`define DSS_OFS_CONTROL_TWO  8'h19

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define DSS_CTRL2_TIMEOUT_BIT 6
`define DSS_CTRL2_RESET       8'h00
`define DSS_LOCK_BIT          0
`define DSS_UNMAPPED_READ     8'h00

// ----------------------------------------
// slave address
// ----------------------------------------
`define DSS_ADDR_UPPER       4'h9
`define DSS_ADDR_LOW_GND     3'h0
`define DSS_ADDR_LOW_FLOAT   3'h2
`define DSS_ADDR_LOW_VCC     3'h3
`define DSS_PIN_LOW          2'h0
`define DSS_PIN_FLOAT        2'h1
`define DSS_PIN_HIGH         2'h2

// ----------------------------------------
// crc and selection
// ----------------------------------------
`define DSS_CRC_POLY         8'h07
`define DSS_CS_PULSES        2'h3

// ----------------------------------------
// timing
// ----------------------------------------
`define DSS_CLK_HZ           20000000
`define DSS_TIMEOUT_MS       25
`define DSS_TIMEOUT_CYCLES   ((`DSS_TIMEOUT_MS * `DSS_CLK_HZ) / 1000)
`define DSS_CNT_W            20

`endif

// file: shared/dss_pkg.sv
/*
 * types of the dual serial slave front end.
 * assumes dss_defs.svh is on the include path.
 */
`default_nettype none
`include "dss_defs.svh"

package dss_pkg;

   // ----------------------------------------
   // bus engine states
   // ----------------------------------------
   typedef enum logic [2:0] {
      DSS_IDLE,
      DSS_ADDR,
      DSS_ADDR_ACK,
      DSS_WR_BYTE,
      DSS_WR_ACK,
      DSS_RD_BYTE,
      DSS_RD_ACK
   } dssState_t;

   typedef logic [`DSS_CNT_W-1:0] dssCnt_t;

   // ----------------------------------------
   // whole module state
   // ----------------------------------------
   typedef struct packed {
      logic       sclS1;
      logic       sclS2;
      logic       sclD;
      logic       sdaS1;
      logic       sdaS2;
      logic       sdaD;
      logic       csS1;
      logic       csS2;
      logic       csD;
      logic [1:0] pinS1;
      logic [1:0] pinS2;
      logic [1:0] csEdges;
      logic       locked;
      dssState_t  st;
      logic [3:0] bitCnt;
      logic [7:0] shift;
      logic       isRead;
      logic [1:0] byteCnt;
      logic [7:0] ptr;
      logic [7:0] dataW;
      logic [7:0] txByte;
      logic       sdaDrv;
      logic [7:0] crc;
      logic       pecOk;
      logic       matchSeen;
      logic       addrLatched;
      logic [2:0] addrLow;
      logic [7:0] ctrlTwo;
      dssCnt_t    toCnt;
   } dssRegs_t;

endpackage : dss_pkg

`default_nettype wire
